// File: src/mpeg_power_gate.sv
// Operation
// (R1) Hold module reset while power-good is low
// (R2) Power-good high starts onboard power sequencing
// (R3) Carrier holds power-good low until stable
// (R4) Carrier delays power-good about 100ms
// (R5) Undriven power-good counts as released
// (R6) Carrier drives low, then tri-states power-good
// (R7) Active-low supply-on output enables ATX supply
// (R8) Button is active-low, debounced, grounded contact; code only synchronises and edge-detects it, with no debounce
// (R9) Button press requests power on or off
// (R10) Synchronise power-good and button before use
`timescale 1ns/1ps
`include "mpeg_defs.svh"
module mpeg_power_gate
  import mpeg_pkg::*;
#(
  parameter int RAIL_STEPS = 3
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  input  wire logic        power_good_in,
  input  wire logic        power_button_n,
  input  wire logic [1:0]  button_action,
  input  wire logic        start_on,
  output logic             supply_on_n,
  output logic [RAIL_STEPS-1:0] rail_enable,
  output logic             module_reset_n,
  output logic             power_is_on
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  mpeg_sync_if sync_bus ();

  mpeg_input_sync u_sync (
    .ref_clk        (ref_clk),
    .rst            (rst),
    .clk_en         (clk_en),
    .power_good_in  (power_good_in),
    .power_button_n (power_button_n),
    .sync_bus       (sync_bus)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic want_on(input logic [1:0] act, input logic is_on);
    case (act)
      `MPEG_ACT_TOGGLE:   want_on = ~is_on;
      `MPEG_ACT_ON_ONLY:  want_on = 1'b1;
      `MPEG_ACT_OFF_ONLY: want_on = 1'b0;
      default:            want_on = is_on;
    endcase
  endfunction

  // ----------------------------------------
  // Sequencer state
  // ----------------------------------------
  mpeg_state_type               state_reg;
  mpeg_state_type               state_next;
  logic [`MPEG_CNT_W-1:0]       cnt_reg;
  logic [`MPEG_CNT_W-1:0]       cnt_next;
  logic [RAIL_STEPS-1:0]        rails_reg;
  logic [RAIL_STEPS-1:0]        rails_next;
  logic                         supply_n_reg;
  logic                         supply_n_next;
  logic                         mreset_n_reg;
  logic                         mreset_n_next;
  logic                         on_reg;
  logic                         on_next;
  logic                         start_done_reg;
  logic                         start_done_next;
  logic                         req_on;
  logic                         req_off;

  always_comb begin
    state_next      = state_reg;
    cnt_next        = cnt_reg;
    rails_next      = rails_reg;
    supply_n_next   = supply_n_reg;
    mreset_n_next   = mreset_n_reg;
    on_next         = on_reg;
    start_done_next = 1'b1;
    req_on          = 1'b0;
    req_off         = 1'b0;
    if (sync_bus.button_press) begin
      req_on  = want_on(button_action, on_reg) & ~on_reg;  // R9
      req_off = ~want_on(button_action, on_reg) & on_reg;  // R9
    end
    // Power-loss policy: come up on first cycle if strapped on
    if (~start_done_reg && start_on)
      req_on = 1'b1;
    case (state_reg)
      MPEG_OFF: begin
        rails_next    = '0;
        supply_n_next = 1'b1;
        mreset_n_next = 1'b0;
        on_next       = 1'b0;
        if (req_on) begin
          state_next    = MPEG_SUPPLY;
          supply_n_next = 1'b0;  // R7
          on_next       = 1'b1;
          cnt_next      = '0;
        end
      end
      MPEG_SUPPLY: begin
        // Give the supply time before judging power-good
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == (`MPEG_CNT_W)'(`MPEG_RST_HOLD_CYC - 1)) begin
          state_next = MPEG_WAIT_PG;
          cnt_next   = '0;
        end
      end
      MPEG_WAIT_PG: begin
        // Pull-up makes an undriven pin read high
        if (sync_bus.power_good_sync) begin  // R2 R5
          state_next = MPEG_RAILS;
          cnt_next   = '0;
        end
      end
      MPEG_RAILS: begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == (`MPEG_CNT_W)'(`MPEG_RAIL_STEP_CYC - 1)) begin
          cnt_next   = '0;
          rails_next = {rails_reg[RAIL_STEPS-2:0], 1'b1};  // R2
          if (rails_reg[RAIL_STEPS-1]) begin
            state_next    = MPEG_RUN;
            mreset_n_next = 1'b1;
          end
        end
      end
      MPEG_RUN: begin
        mreset_n_next = 1'b1;
      end
      default: begin
        state_next = MPEG_OFF;
      end
    endcase
    // Power-good loss re-enters reset in any powered state after MPEG_SUPPLY
    if (on_next && state_reg != MPEG_SUPPLY && state_reg != MPEG_OFF && ~sync_bus.power_good_sync) begin
      state_next    = MPEG_WAIT_PG;  // R1
      mreset_n_next = 1'b0;  // R1
      rails_next    = '0;
      cnt_next      = '0;
    end
    if (req_off) begin
      state_next    = MPEG_OFF;
      supply_n_next = 1'b1;  // R7
      mreset_n_next = 1'b0;
      rails_next    = '0;
      on_next       = 1'b0;
      cnt_next      = '0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg      <= MPEG_OFF;
      cnt_reg        <= '0;
      rails_reg      <= '0;
      supply_n_reg   <= 1'b1;
      mreset_n_reg   <= 1'b0;
      on_reg         <= 1'b0;
      start_done_reg <= 1'b0;
    end else if (clk_en) begin
      state_reg      <= state_next;
      cnt_reg        <= cnt_next;
      rails_reg      <= rails_next;
      supply_n_reg   <= supply_n_next;
      mreset_n_reg   <= mreset_n_next;
      on_reg         <= on_next;
      start_done_reg <= start_done_next;
    end
  end

  assign supply_on_n    = supply_n_reg;
  assign rail_enable    = rails_reg;
  assign module_reset_n = mreset_n_reg;
  assign power_is_on    = on_reg;

endmodule

// File: include/mpeg_defs.svh
`ifndef MPEG_DEFS_SVH
`define MPEG_DEFS_SVH

// Clock rate and timing
`define MPEG_CLK_HZ          125000000
`define MPEG_RST_HOLD_US     10
`define MPEG_RST_HOLD_CYC    ((`MPEG_CLK_HZ / 1000000) * `MPEG_RST_HOLD_US)
`define MPEG_RAIL_STEP_US    20
`define MPEG_RAIL_STEP_CYC   ((`MPEG_CLK_HZ / 1000000) * `MPEG_RAIL_STEP_US)
`define MPEG_CNT_W           16

// Button action encodings
`define MPEG_ACT_TOGGLE      2'h0
`define MPEG_ACT_ON_ONLY     2'h1
`define MPEG_ACT_OFF_ONLY    2'h2
`define MPEG_ACT_IGNORE      2'h3

`endif

// File: include/mpeg_pkg.sv
package mpeg_pkg;

  typedef enum logic [4:0] {
    MPEG_OFF      = 5'h01,
    MPEG_SUPPLY   = 5'h02,
    MPEG_WAIT_PG  = 5'h04,
    MPEG_RAILS    = 5'h08,
    MPEG_RUN      = 5'h10
  } mpeg_state_type;

endpackage

// File: include/mpeg_sync_if.sv
`timescale 1ns/1ps
interface mpeg_sync_if;
  logic power_good_sync;
  logic button_press;

  modport producer (output power_good_sync, output button_press);
  modport consumer (input  power_good_sync, input  button_press);
endinterface

// File: src/mpeg_input_sync.sv
`timescale 1ns/1ps
module mpeg_input_sync (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       clk_en,
  input  wire logic       power_good_in,
  input  wire logic       power_button_n,
  mpeg_sync_if.producer   sync_bus
);

  logic [1:0] pg_reg;
  logic [1:0] pg_next;
  logic [1:0] btn_reg;
  logic [1:0] btn_next;
  logic       btn_prev_reg;
  logic       btn_prev_next;

  always_comb begin
    pg_next       = {pg_reg[0], power_good_in};  // R10
    btn_next      = {btn_reg[0], ~power_button_n};  // R10
    btn_prev_next = btn_reg[1];
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pg_reg       <= 2'h0;
      btn_reg      <= 2'h0;
      btn_prev_reg <= 1'h0;
    end else if (clk_en) begin
      pg_reg       <= pg_next;
      btn_reg      <= btn_next;
      btn_prev_reg <= btn_prev_next;
    end
  end

  // Press edge only; a held button makes one request
  assign sync_bus.power_good_sync = pg_reg[1];
  assign sync_bus.button_press    = btn_reg[1] & ~btn_prev_reg;  // R9

endmodule

// File: testbench/mpeg_gate_properties.sv
`timescale 1ns/1ps
module mpeg_gate_checker #(
  parameter int RAIL_STEPS = 3
) (
  input wire logic                  ref_clk,
  input wire logic                  rst,
  input wire logic                  power_good_in,
  input wire logic                  power_button_n,
  input wire logic [1:0]            button_action,
  input wire logic                  supply_on_n,
  input wire logic [RAIL_STEPS-1:0] rail_enable,
  input wire logic                  module_reset_n,
  input wire logic                  power_is_on
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ----------
  // Checks
  // ----------
  a_pg_low_hold: assert property (!power_good_in [*5] |-> !module_reset_n)
    else $error("reset released with power good low");
  a_boot_after_rails: assert property ($rose(module_reset_n) |-> power_good_in && &rail_enable && !supply_on_n)
    else $error("reset released before sequencing ended");
  a_supply_first: assert property ($fell(supply_on_n) |-> power_is_on ##1 (rail_enable == '0) [*8])
    else $error("rails enabled with the supply");
  a_off_all_low: assert property (supply_on_n |-> !power_is_on && rail_enable == '0 && !module_reset_n)
    else $error("outputs active with supply off");
  a_sync_delay: assert property ($fell(power_button_n) |=> $stable(power_is_on) [*2])
    else $error("press acted on before synchronising");
  a_toggle_on: assert property ($fell(power_button_n) && button_action == 2'h0 && !power_is_on |-> ##[3:5] power_is_on)
    else $error("toggle press did not power on");
  a_ignore_press: assert property ($fell(power_button_n) && button_action == 2'h3 |=> $stable(power_is_on) [*6])
    else $error("ignored press changed power");
  cover property ($rose(module_reset_n));
  cover property ($fell(power_is_on));
  cover property ($fell(module_reset_n) && power_is_on);
endmodule

bind mpeg_power_gate mpeg_gate_checker #(.RAIL_STEPS(RAIL_STEPS)) chk (
  .ref_clk(ref_clk), .rst(rst), .power_good_in(power_good_in), .power_button_n(power_button_n),
  .button_action(button_action), .supply_on_n(supply_on_n), .rail_enable(rail_enable),
  .module_reset_n(module_reset_n), .power_is_on(power_is_on));

// File: testbench/mpeg_carrier_model.sv
`timescale 1ns/1ps
module mpeg_carrier_model (
  input wire logic hold_low,
  input wire logic pressed,
  inout wire       power_good_in,
  inout wire       power_button_n
);
  // Float rather than drive high, avoiding back-driving the module
  assign power_good_in = hold_low ? 1'h0 : 1'hz;
  // Contact to ground only; the pull-up gives the idle level
  assign power_button_n = pressed ? 1'h0 : 1'hz;
endmodule

// File: testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic        ref_clk, rst, hold_low, pressed, clk_en, start_on;
  logic [1:0]  button_action;
  tri1         pg_line, btn_line;
  logic        supply_on_n, module_reset_n, power_is_on;
  logic [2:0]  rail_enable, prev = 3'h4;
  logic [2:0]  exp_q[$];
  logic [31:0] seed = 32'h749D7F69;
  int          mismatches = 0, checks = 0;

  mpeg_power_gate dut (
    .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .power_good_in(pg_line), .power_button_n(btn_line),
    .button_action(button_action), .start_on(start_on), .supply_on_n(supply_on_n), .rail_enable(rail_enable),
    .module_reset_n(module_reset_n), .power_is_on(power_is_on));
  mpeg_carrier_model carrier (
    .hold_low(hold_low), .pressed(pressed), .power_good_in(pg_line), .power_button_n(btn_line));

  initial begin
    ref_clk = 1'h0;
    forever #4 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic compare(input string name, input logic [2:0] exp, input logic [2:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic press(input logic [1:0] act);
    button_action = act;
    pressed = 1'h1;
    seed = xorshift(seed);
    repeat (4 + seed[2:0]) @(negedge ref_clk);
    pressed = 1'h0;
    repeat (10) @(negedge ref_clk);
  endtask

  // ----------
  // Output watcher
  // ----------
  always @(negedge ref_clk) begin
    if (!rst && {supply_on_n, module_reset_n, power_is_on} !== prev) begin
      prev = {supply_on_n, module_reset_n, power_is_on};
      compare("state", exp_q.size() ? exp_q.pop_front() : ~prev, prev);
    end
  end

  initial begin
    repeat (80000) @(posedge ref_clk);
    mismatches++;
    finish_test;
  end

  initial begin
    logic       on;
    logic [1:0] act;
    rst           = 1'h1;
    hold_low      = 1'h1;
    pressed       = 1'h0;
    button_action = 2'h3;
    clk_en        = 1'h1;
    start_on      = 1'h1;
    repeat (16) @(negedge ref_clk);
    compare("reset", 3'h4, {supply_on_n, module_reset_n, power_is_on});
    exp_q.push_back(3'h1);
    exp_q.push_back(3'h3);
    rst = 1'h0;
    repeat (3000) @(negedge ref_clk);
    hold_low = 1'h0;
    repeat (11000) @(negedge ref_clk);
    compare("rails", 3'h7, rail_enable);
    $display("test start_on done");
    exp_q.push_back(3'h1);
    exp_q.push_back(3'h3);
    hold_low = 1'h1;
    repeat (100) @(negedge ref_clk);
    compare("rails", 3'h0, rail_enable);
    hold_low = 1'h0;
    repeat (10300) @(negedge ref_clk);
    $display("test power_good_drop done");
    // Frozen block must ignore an off-only press entirely
    clk_en = 1'h0;
    press(2'h2);
    clk_en = 1'h1;
    repeat (8) @(negedge ref_clk);
    compare("freeze", 3'h3, {supply_on_n, module_reset_n, power_is_on});
    $display("test clock_enable done");
    on = 1'h1;
    for (int i = 0; i < 6; i++) begin
      seed = xorshift(seed);
      act = (i < 4) ? i[1:0] : seed[1:0];
      if (act == 2'h0 || (act == 2'h1 && !on) || (act == 2'h2 && on)) begin
        on = !on;
        exp_q.push_back(on ? 3'h1 : 3'h4);
        if (on) exp_q.push_back(3'h3);
      end
      press(act);
      if (on) repeat (11400) @(negedge ref_clk);
      $display("test press %0d done", act);
    end
    // Mid-run reset with the always-on strap low: must stay off
    if (on) exp_q.push_back(3'h4);
    rst      = 1'h1;
    start_on = 1'h0;
    repeat (4) @(negedge ref_clk);
    rst = 1'h0;
    repeat (50) @(negedge ref_clk);
    compare("restart", 3'h4, {supply_on_n, module_reset_n, power_is_on});
    exp_q.push_back(3'h1);
    exp_q.push_back(3'h4);
    press(2'h0);
    press(2'h0);
    $display("test restart done");
    compare("pending", 3'h0, 3'(exp_q.size()));
    finish_test;
  end
endmodule
